// [rca_pkg.sv]
// Purpose: shared constants and types of the core execution datapath
// Assumes: one instruction cycle per clk cycle
// Notes: opcode layout follows the usual 14-bit single-word encoding
package rca_pkg;
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int PC_W = 13;
    localparam int FADDR_W = 9;
    localparam int CLK_PERIOD_NS = 10;
    localparam int INSTR_CYCLE_NS = 200;
    localparam int CYCLE_CLKS = (INSTR_CYCLE_NS / CLK_PERIOD_NS < 1) ? 1 :
        INSTR_CYCLE_NS / CLK_PERIOD_NS;
    // special function register addresses (low 7 bits)
    localparam logic [6:0] SFR_INDF = 7'h00;
    localparam logic [6:0] SFR_PCL = 7'h02;
    localparam logic [6:0] SFR_STATUS = 7'h03;
    localparam logic [6:0] SFR_FSR = 7'h04;
    localparam logic [6:0] SFR_PCLATH = 7'h0A;
    // status bit positions
    localparam int ST_CARRY = 0;
    localparam int ST_NIBBLE = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_RP0 = 5;
    localparam int ST_RP1 = 6;
    localparam int ST_IRP = 7;
    // reset values
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [DATA_W-1:0] STATUS_RESET = 8'h18;
    localparam logic [INSTR_W-1:0] NOP_WORD = 14'h0000;
    typedef enum logic [3:0] {
        RCA_OP_PASS_A, RCA_OP_PASS_B, RCA_OP_ADD, RCA_OP_SUB, RCA_OP_AND,
        RCA_OP_OR, RCA_OP_XOR, RCA_OP_COM, RCA_OP_INC, RCA_OP_DEC,
        RCA_OP_RL, RCA_OP_RR, RCA_OP_SWAP, RCA_OP_BCLR, RCA_OP_BSET
    } rca_op_t;
endpackage : rca_pkg

// [rca_alu_if.sv]
// Purpose: operand and result bundle between the core and its alu
// Assumes: single clock, purely combinational alu
// Notes: none
`timescale 1ns/1ns
`default_nettype none
interface rca_alu_if;
    import rca_pkg::*;
    rca_op_t op;
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] b;
    logic [2:0] bit_sel;
    logic carry_in;
    logic [DATA_W-1:0] y;
    logic carry_out;
    logic nibble_out;
    logic zero_out;
    modport core (output op, a, b, bit_sel, carry_in,
        input y, carry_out, nibble_out, zero_out);
    modport alu (input op, a, b, bit_sel, carry_in,
        output y, carry_out, nibble_out, zero_out);
endinterface : rca_alu_if
`default_nettype wire

// [rca_alu.sv]
// Purpose: 8-bit two's complement alu with carry, nibble carry and zero
// Assumes: a is the accumulator or file, b the file, accumulator or constant
// Notes: subtract computes b - a, carry and nibble carry mean no borrow
`timescale 1ns/1ns
`default_nettype none
module rca_alu (
    rca_alu_if.alu p
);
    import rca_pkg::*;
    logic [DATA_W:0] sum;
    logic [4:0] nib;
    logic [DATA_W-1:0] mask;
    always_comb begin
        sum = '0;
        nib = '0;
        mask = 8'h01 << p.bit_sel;
        p.y = p.a;
        p.carry_out = p.carry_in;
        p.nibble_out = 1'b0;
        case (p.op)
            RCA_OP_PASS_A: p.y = p.a;
            RCA_OP_PASS_B: p.y = p.b;
            RCA_OP_ADD: begin
                sum = {1'b0, p.a} + {1'b0, p.b};
                nib = {1'b0, p.a[3:0]} + {1'b0, p.b[3:0]};
                p.y = sum[DATA_W-1:0];
                p.carry_out = sum[DATA_W];
                p.nibble_out = nib[4];
            end
            RCA_OP_SUB: begin
                // two's complement add of the negated operand
                sum = {1'b0, p.b} + {1'b0, ~p.a} + 9'h001;
                nib = {1'b0, p.b[3:0]} + {1'b0, ~p.a[3:0]} + 5'h01;
                p.y = sum[DATA_W-1:0];
                p.carry_out = sum[DATA_W];
                p.nibble_out = nib[4];
            end
            RCA_OP_AND: p.y = p.a & p.b;
            RCA_OP_OR: p.y = p.a | p.b;
            RCA_OP_XOR: p.y = p.a ^ p.b;
            RCA_OP_COM: p.y = ~p.a;
            RCA_OP_INC: p.y = p.a + 8'h01;
            RCA_OP_DEC: p.y = p.a - 8'h01;
            RCA_OP_RL: begin
                p.y = {p.a[6:0], p.carry_in};
                p.carry_out = p.a[7];
            end
            RCA_OP_RR: begin
                p.y = {p.carry_in, p.a[7:1]};
                p.carry_out = p.a[0];
            end
            RCA_OP_SWAP: p.y = {p.a[3:0], p.a[7:4]};
            RCA_OP_BCLR: p.y = p.a & ~mask;
            RCA_OP_BSET: p.y = p.a | mask;
            default: p.y = p.a;
        endcase
    end
    assign p.zero_out = (p.y == 8'h00);
endmodule : rca_alu
`default_nettype wire

// [rca_core.sv]
// Purpose: execution datapath of an 8-bit harvard risc core
// Assumes: one instruction cycle per clk, program and data memory outside
// Notes: data memory read is combinational, write at the clock edge
//
// Functional notes
// - program and data use separate memories on separate buses.
// - every opcode is one 14-bit word in one program location.
// - one full instruction word is fetched each instruction cycle.
// - fetch of the next word overlaps execution of the current one.
// - each non-branch instruction completes in one instruction cycle.
// - data memory is reached by a direct address or via a pointer.
// - special registers, the program counter too, sit in data space.
// - the alu works on bytes and adds, subtracts, shifts and masks.
// - arithmetic is two's complement.
// - two-operand work uses the accumulator and a file or constant.
// - single-operand work uses the accumulator or a file register.
// - the accumulator is one byte and has no data address.
// - results update carry, nibble carry and zero in the status.
// - in subtraction carry and nibble carry mean no borrow.
`timescale 1ns/1ns
`default_nettype none
module rca_core (
    input wire logic clk,
    input wire logic reset,
    output logic [rca_pkg::PC_W-1:0] prog_addr,
    input wire logic [rca_pkg::INSTR_W-1:0] prog_data,
    output logic [rca_pkg::FADDR_W-1:0] data_addr,
    input wire logic [rca_pkg::DATA_W-1:0] data_rdata,
    output logic [rca_pkg::DATA_W-1:0] data_wdata,
    output logic data_we,
    output logic [rca_pkg::DATA_W-1:0] acc_out,
    output logic [rca_pkg::DATA_W-1:0] status_out,
    output logic flush_out
);
    import rca_pkg::*;
    logic [PC_W-1:0] pc_r, pc_nxt;
    logic [INSTR_W-1:0] ir_r, ir_nxt;
    logic [DATA_W-1:0] acc_r, acc_nxt;
    logic [DATA_W-1:0] status_r, status_nxt;
    logic [DATA_W-1:0] fsr_r, fsr_nxt;
    logic [DATA_W-1:0] pclath_r, pclath_nxt;
    logic [DATA_W-1:0] wdata_r, wdata_nxt;
    logic [FADDR_W-1:0] waddr_r;
    logic we_r, we_nxt;
    logic flush_r, flush_nxt;
    rca_alu_if alu_bus ();
    rca_alu u_alu (.p(alu_bus));

    ////////////////////////////////////////////////////////////////////////
    // decode fields
    function automatic logic is_sfr(input logic [6:0] a, input logic [6:0] s);
        is_sfr = (a == s);
    endfunction : is_sfr
    wire [6:0] f_low = ir_r[6:0];
    wire d_bit = ir_r[7];
    wire [2:0] b_sel = ir_r[9:7];
    wire [7:0] k8 = ir_r[7:0];
    wire [1:0] grp = ir_r[13:12];
    wire [3:0] sub_op = ir_r[11:8];
    wire indirect = is_sfr(f_low, SFR_INDF);
    wire [FADDR_W-1:0] rd_addr = indirect ? {status_r[ST_IRP], fsr_r} :
        {status_r[ST_RP1], status_r[ST_RP0], f_low};
    wire [6:0] rd_low = rd_addr[6:0];
    // special registers are read from the core, the rest from memory
    wire [DATA_W-1:0] file_val =
        is_sfr(rd_low, SFR_STATUS) ? status_r :
        is_sfr(rd_low, SFR_FSR) ? fsr_r :
        is_sfr(rd_low, SFR_PCL) ? pc_r[7:0] :
        is_sfr(rd_low, SFR_PCLATH) ? pclath_r : data_rdata;
    wire byte_op = (grp == 2'b00);
    wire bit_op = (grp == 2'b01);
    wire lit_op = (grp == 2'b11);
    wire flow_op = (grp == 2'b10);
    wire skip_test = bit_op && sub_op[3];
    wire bit_val = file_val[b_sel];
    wire dec_skip = byte_op && (sub_op == 4'hB || sub_op == 4'hF);

    ////////////////////////////////////////////////////////////////////////
    // operand and operation selection
    always_comb begin
        alu_bus.op = RCA_OP_PASS_A;
        alu_bus.a = acc_r;
        alu_bus.b = file_val;
        alu_bus.bit_sel = b_sel;
        alu_bus.carry_in = status_r[ST_CARRY];
        if (byte_op) begin
            alu_bus.a = file_val;
            alu_bus.b = acc_r;
            case (sub_op)
                4'h0: alu_bus.a = acc_r;
                4'h1: alu_bus.op = RCA_OP_BCLR;
                4'h2: begin
                    alu_bus.op = RCA_OP_SUB;
                    alu_bus.a = acc_r;
                    alu_bus.b = file_val;
                end
                4'h3, 4'hB: alu_bus.op = RCA_OP_DEC;
                4'h4: alu_bus.op = RCA_OP_OR;
                4'h5: alu_bus.op = RCA_OP_AND;
                4'h6: alu_bus.op = RCA_OP_XOR;
                4'h7: alu_bus.op = RCA_OP_ADD;
                4'h9: alu_bus.op = RCA_OP_COM;
                4'hA, 4'hF: alu_bus.op = RCA_OP_INC;
                4'hC: alu_bus.op = RCA_OP_RR;
                4'hD: alu_bus.op = RCA_OP_RL;
                4'hE: alu_bus.op = RCA_OP_SWAP;
                default: alu_bus.op = RCA_OP_PASS_A;
            endcase
            if (sub_op == 4'h1) begin
                alu_bus.a = d_bit ? file_val : acc_r;
                alu_bus.bit_sel = 3'h0;
                alu_bus.op = RCA_OP_AND;
                alu_bus.b = 8'h00;
            end
        end else if (bit_op) begin
            alu_bus.a = file_val;
            alu_bus.op = sub_op[2] ? RCA_OP_BSET : RCA_OP_BCLR;
        end else if (lit_op) begin
            alu_bus.a = acc_r;
            alu_bus.b = k8;
            case (sub_op)
                4'h8: alu_bus.op = RCA_OP_OR;
                4'h9: alu_bus.op = RCA_OP_AND;
                4'hA: alu_bus.op = RCA_OP_XOR;
                4'hC, 4'hD: alu_bus.op = RCA_OP_SUB;
                4'hE, 4'hF: alu_bus.op = RCA_OP_ADD;
                default: alu_bus.op = RCA_OP_PASS_B;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // writeback, flags and program flow
    wire arith = (byte_op && (sub_op == 4'h2 || sub_op == 4'h7)) ||
        (lit_op && sub_op[3:2] == 2'b11);
    wire rot = byte_op && (sub_op == 4'hC || sub_op == 4'hD);
    wire z_aff = (byte_op && !rot && sub_op != 4'hE && !dec_skip &&
        sub_op != 4'h0) || (lit_op && sub_op[3]);
    wire to_file = (byte_op && d_bit && sub_op != 4'h0) || bit_op &&
        !skip_test || (byte_op && sub_op == 4'h0 && d_bit);
    wire w_src_file = byte_op && sub_op == 4'h0 && d_bit;
    wire [DATA_W-1:0] res = w_src_file ? acc_r : alu_bus.y;
    wire skip = (skip_test && (bit_val == sub_op[2])) ||
        (dec_skip && alu_bus.zero_out);
    wire jump = flow_op;
    wire wr_sfr_pcl = to_file && is_sfr(rd_low, SFR_PCL);

    always_comb begin
        pc_nxt = pc_r + 13'h0001;
        ir_nxt = prog_data;
        flush_nxt = 1'b0;
        acc_nxt = acc_r;
        status_nxt = status_r;
        fsr_nxt = fsr_r;
        pclath_nxt = pclath_r;
        wdata_nxt = res;
        we_nxt = 1'b0;
        if (!flush_r) begin
            if (arith) begin
                status_nxt[ST_CARRY] = alu_bus.carry_out;
                status_nxt[ST_NIBBLE] = alu_bus.nibble_out;
            end
            if (rot) status_nxt[ST_CARRY] = alu_bus.carry_out;
            if (z_aff) status_nxt[ST_ZERO] = alu_bus.zero_out;
            if (to_file) begin
                if (is_sfr(rd_low, SFR_STATUS)) begin
                    status_nxt = res;
                end else if (is_sfr(rd_low, SFR_FSR)) begin
                    fsr_nxt = res;
                end else if (is_sfr(rd_low, SFR_PCLATH)) begin
                    pclath_nxt = res;
                end else if (!wr_sfr_pcl) begin
                    we_nxt = 1'b1;
                end
            end else if (!skip_test && !jump) begin
                acc_nxt = res;
            end
            if (jump) begin
                pc_nxt = {pclath_r[4:3], ir_r[10:0]};
                flush_nxt = 1'b1;
            end else if (wr_sfr_pcl) begin
                pc_nxt = {pclath_r[4:0], res};
                flush_nxt = 1'b1;
            end else if (skip) begin
                flush_nxt = 1'b1;
            end
        end
        if (flush_nxt) ir_nxt = NOP_WORD;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pc_r <= PC_RESET;
            ir_r <= NOP_WORD;
            acc_r <= 8'h00;
            status_r <= STATUS_RESET;
            fsr_r <= 8'h00;
            pclath_r <= 8'h00;
            wdata_r <= 8'h00;
            we_r <= 1'b0;
            flush_r <= 1'b0;
            waddr_r <= '0;
        end else begin
            pc_r <= pc_nxt;
            ir_r <= ir_nxt;
            acc_r <= acc_nxt;
            status_r <= status_nxt;
            fsr_r <= fsr_nxt;
            pclath_r <= pclath_nxt;
            wdata_r <= wdata_nxt;
            we_r <= we_nxt;
            flush_r <= flush_nxt;
            waddr_r <= rd_addr;
        end
    end

    assign prog_addr = pc_r;
    assign data_addr = we_r ? waddr_r : rd_addr;
    assign data_wdata = wdata_r;
    assign data_we = we_r;
    assign acc_out = acc_r;
    assign status_out = status_r;
    assign flush_out = flush_r;
endmodule : rca_core
`default_nettype wire

// [rca_core_chk.sv]
// Purpose: port checker of the core
// Assumes: no flow word follows another flow word
// Notes: a fetched word counts only when no flush follows it
`timescale 1ns/1ns
`default_nettype none
module rca_core_chk (
    input wire logic clk,
    input wire logic reset,
    input wire logic [rca_pkg::PC_W-1:0] prog_addr,
    input wire logic [rca_pkg::INSTR_W-1:0] prog_data,
    input wire logic [rca_pkg::FADDR_W-1:0] data_addr,
    input wire logic [rca_pkg::DATA_W-1:0] data_rdata,
    input wire logic [rca_pkg::DATA_W-1:0] data_wdata,
    input wire logic data_we,
    input wire logic [rca_pkg::DATA_W-1:0] acc_out,
    input wire logic [rca_pkg::DATA_W-1:0] status_out,
    input wire logic flush_out
);
    import rca_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_ex(hit);
        hit ##1 !flush_out;
    endsequence
    ////////////////////////////////////////////////////////////
    property p_goto;
        s_ex(prog_data[13:11] == 3'b101) |-> ##1 flush_out
            && prog_addr[10:0] == $past(prog_data[10:0], 2);
    endproperty
    a_goto: assert property (p_goto)
        else $error("goto missed");
    property p_add;
        s_ex(prog_data[13:9] == 5'h1F) |-> ##1 {status_out[0], acc_out}
            == $past(prog_data[7:0], 2) + $past(acc_out, 1);
    endproperty
    a_add: assert property (p_add)
        else $error("add wrong");
    property p_sub;
        s_ex(prog_data[13:9] == 5'h1E) |-> ##1 acc_out == $past(prog_data[7:0],
            2) - $past(acc_out, 1) && status_out[0] ==
            ($past(prog_data[7:0], 2) >= $past(acc_out, 1));
    endproperty
    a_sub: assert property (p_sub)
        else $error("sub wrong");
    property p_nib;
        s_ex(prog_data[13:9] == 5'h1E) |-> ##1 status_out[1] ==
            ($past(prog_data[3:0], 2) >= $past(acc_out[3:0], 1));
    endproperty
    a_nib: assert property (p_nib)
        else $error("nibble borrow wrong");
    property p_zero;
        s_ex(prog_data[13:11] == 3'b111) |-> ##1
            status_out[2] == (acc_out == 8'h00);
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero flag wrong");
    property p_movlw;
        s_ex(prog_data[13:10] == 4'hC) |-> ##1
            acc_out == $past(prog_data[7:0], 2) && $stable(status_out);
    endproperty
    a_movlw: assert property (p_movlw)
        else $error("load constant wrong");
    property p_movwf;
        s_ex(prog_data[13:7] == 7'h01 && prog_data[6:5] != 2'b00) |-> ##1
            data_we && data_wdata == $past(acc_out, 1) &&
            data_addr[6:0] == $past(prog_data[6:0], 2);
    endproperty
    a_movwf: assert property (p_movwf)
        else $error("store wrong");
    property p_addwf;
        s_ex(prog_data[13:7] == 7'h0E && prog_data[6:5] != 2'b00) |-> ##1
            acc_out == $past(data_rdata, 1) + $past(acc_out, 1);
    endproperty
    a_addwf: assert property (p_addwf)
        else $error("file add wrong");
endmodule : rca_core_chk
bind rca_core rca_core_chk rca_core_chk_inst (.clk(clk), .reset(reset),
    .prog_addr(prog_addr), .prog_data(prog_data), .data_addr(data_addr),
    .data_rdata(data_rdata), .data_wdata(data_wdata), .data_we(data_we),
    .acc_out(acc_out), .status_out(status_out), .flush_out(flush_out));
`default_nettype wire

// [rca_mem_model.sv]
// Purpose: program and data memory beside the core
// Assumes: reads combinational, writes at the clock edge
// Notes: read data is inverted while a write is pending
`timescale 1ns/1ns
`default_nettype none
module rca_mem_model (
    input wire logic clk,
    input wire logic [rca_pkg::PC_W-1:0] prog_addr,
    output logic [rca_pkg::INSTR_W-1:0] prog_data,
    input wire logic [rca_pkg::FADDR_W-1:0] data_addr,
    output logic [rca_pkg::DATA_W-1:0] data_rdata,
    input wire logic [rca_pkg::DATA_W-1:0] data_wdata,
    input wire logic data_we
);
    import rca_pkg::*;
    logic [INSTR_W-1:0] rom [2**PC_W];
    logic [DATA_W-1:0] ram [2**FADDR_W];
    initial begin
        for (int i = 0; i < 2**PC_W; i++) rom[i] = NOP_WORD;
    end
    assign prog_data = rom[prog_addr];
    assign data_rdata = data_we ? ~ram[data_addr] : ram[data_addr];
    always @(posedge clk) begin
        if (data_we) ram[data_addr] <= data_wdata;
    end
endmodule : rca_mem_model
`default_nettype wire

// [rca_core_tb_top.sv]
// Purpose: self-checking bench of the core
// Assumes: usual 14-bit encoding, programs of six words
// Notes: no flow word follows another
`timescale 1ns/1ns
`default_nettype none
module rca_core_tb_top;
    import rca_pkg::*;
    logic clk;
    logic reset = 1'b1;
    logic [PC_W-1:0] prog_addr;
    logic [INSTR_W-1:0] prog_data;
    logic [FADDR_W-1:0] data_addr;
    logic [DATA_W-1:0] data_rdata;
    logic [DATA_W-1:0] data_wdata;
    logic data_we;
    logic [DATA_W-1:0] acc_out;
    logic [DATA_W-1:0] status_out;
    logic flush_out;
    int n_errors = 0;
    int tests_run = 0;
    int n_flush = 0;
    int seed = 32'h369c;
    logic [13:0] pg [6];
    logic [7:0] w;
    logic [7:0] v;
    logic [13:0] lw [8] = '{14'h3E80, 14'h3E0F, 14'h3C05, 14'h3C03,
        14'h3C10, 14'h39F0, 14'h38A0, 14'h3AFF};
    logic [7:0] la [8] = '{8'h80, 8'h01, 8'h05, 8'h05, 8'h01, 8'h0F, 8'h05,
        8'hFF};
    logic [5:0] ops [5] = '{6'h3E, 6'h3C, 6'h39, 6'h38, 6'h3A};
    rca_core rca_core_inst (.clk(clk), .reset(reset), .prog_addr(prog_addr),
        .prog_data(prog_data), .data_addr(data_addr),
        .data_rdata(data_rdata), .data_wdata(data_wdata), .data_we(data_we),
        .acc_out(acc_out), .status_out(status_out), .flush_out(flush_out));
    rca_mem_model rca_mem_model_inst (.clk(clk), .prog_addr(prog_addr),
        .prog_data(prog_data), .data_addr(data_addr), .data_we(data_we),
        .data_rdata(data_rdata), .data_wdata(data_wdata));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (flush_out === 1'b1) n_flush++;
    end
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test
    task automatic run(input int n);
        for (int i = 0; i < 6; i++) rca_mem_model_inst.rom[i] = pg[i];
        reset = 1'b1;
        repeat (20) @(posedge clk);
        check({acc_out, status_out}, {8'h00, STATUS_RESET});
        #1 reset = 1'b0;
        n_flush = 0;
        repeat (n) @(posedge clk);
        #1;
    endtask : run
    function automatic logic [10:0] exp_lit(input logic [13:0] wd,
            input logic [7:0] a);
        logic [7:0] k = wd[7:0];
        logic [8:0] r = 9'h000;
        logic c = 1'b0;
        logic dc = 1'b0;
        case (wd[11:8])
            4'h8: r = {1'b0, k | a};
            4'h9: r = {1'b0, k & a};
            4'hA: r = {1'b0, k ^ a};
            4'hC: begin
                r = {1'b0, k - a};
                c = k >= a;
                dc = k[3:0] >= a[3:0];
            end
            default: begin
                r = k + a;
                c = r[8];
                dc = (k[3:0] + a[3:0]) > 5'h0F;
            end
        endcase
        return {c, dc, r[7:0] == 8'h00, r[7:0]};
    endfunction : exp_lit
    task automatic lit(input logic [13:0] wd, input logic [7:0] a);
        logic [10:0] e;
        e = exp_lit(wd, a);
        pg = '{14'h3000 | a, wd, NOP_WORD, NOP_WORD, NOP_WORD, NOP_WORD};
        run(5);
        check(acc_out, e[7:0]);
        check({status_out[0], status_out[1], status_out[2]}, e[10:8]);
    endtask : lit
    ////////////////////////////////////////////////////////////
    initial begin
        pg = '{default: NOP_WORD};
        run(0);
        for (int i = 1; i < 7; i++) begin
            @(posedge clk);
            #1 check(16'(prog_addr), 16'(i));
        end
        $display("test fetch done");
        for (int i = 0; i < 8; i++) lit(lw[i], la[i]);
        for (int i = 0; i < 40; i++) begin
            w = 8'($random(seed));
            v = 8'($random(seed));
            lit({ops[i % 5], v}, w);
        end
        $display("test literal done");
        for (int i = 0; i < 4; i++) begin
            w = 8'($random(seed));
            v = 8'($random(seed));
            rca_mem_model_inst.ram[9'h025] = v;
            pg = '{14'h3000 | w, 14'h00B0, NOP_WORD, 14'h0725, NOP_WORD,
                NOP_WORD};
            run(6);
            check({status_out[0], acc_out}, w + v);
            check(rca_mem_model_inst.ram[9'h030], w);
        end
        pg = '{14'h0803, NOP_WORD, NOP_WORD, NOP_WORD, NOP_WORD, NOP_WORD};
        run(4);
        check(acc_out, STATUS_RESET);
        $display("test file done");
        pg = '{14'h2805, 14'h3011, NOP_WORD, NOP_WORD, NOP_WORD, 14'h3022};
        run(6);
        check(acc_out, 8'h22);
        check(16'(n_flush), 16'h0001);
        $display("test jump done");
        v = 8'($random(seed));
        rca_mem_model_inst.ram[9'h030] = v;
        pg = '{14'h15B0, NOP_WORD, 14'h1DB0, 14'h3011, NOP_WORD, NOP_WORD};
        run(6);
        check(rca_mem_model_inst.ram[9'h030], v | 8'h08);
        check(acc_out, 8'h00);
        check(16'(n_flush), 16'h0001);
        pg = '{14'h3030, 14'h0084, 14'h0800, NOP_WORD, NOP_WORD, NOP_WORD};
        run(5);
        check(acc_out, v | 8'h08);
        $display("test bit and pointer done");
        finish_test();
    end
    initial begin
        #300000;
        n_errors++;
        finish_test();
    end
endmodule : rca_core_tb_top
`default_nettype wire
